// ===== rtl/jtag_isp_config_port.sv
// jtag in-system configuration port with status and error extension pins
`timescale 1ns/1ps
module jtag_isp_config_port
  import jtag_isc_pkg::*;
(
  // system clock domain
  input  wire logic     sys_clk,
  input  wire logic     rst_b,
  input  wire logic     clk_en,
  // test-access pins, link clock domain
  input  wire logic     tck,
  input  wire logic     tms,
  input  wire logic     tdi,
  output pin_drv_s      tdo_pin,
  // chip reset pin, asynchronous
  input  wire logic     chip_rst_b,
  // flash section
  input  wire logic     flash_busy,
  input  wire logic     flash_err,
  output flash_req_s    flash_req,
  output logic          flash_req_valid,
  // ordinary drive of the two shared pins
  input  wire pin_drv_s port_stat_drv,
  input  wire pin_drv_s port_err_drv,
  // extension pins
  output pin_drv_s      prog_status_out,
  output pin_drv_s      prog_error_flag
);

  // ==========================================================
  // link domain declarations
  logic [1:0]        tck_rst_q;
  tap_state_e        st_q;
  tap_state_e        st_d;
  logic [IR_W-1:0]   ir_sr_q;
  logic [IR_W-1:0]   ir_q;
  logic [LOAD_W-1:0] dr_q;
  logic [OPT_W-1:0]  sdr_q;
  logic              byp_q;
  logic              chan_en_q;
  logic [OPT_W-1:0]  opt_q;
  logic              req_tgl_q;
  logic              dis_tgl_q;
  logic              clr_tgl_q;
  flash_req_s        req_hold_q;
  back_s             back_s1_q;
  back_s             back_s2_q;

  wire logic tck_ok = tck_rst_q[1];

  // ==========================================================
  // tap controller
  always_comb begin
    case (st_q)
      TAP_RESET:  st_d = tms ? TAP_RESET  : TAP_IDLE;
      TAP_IDLE:   st_d = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: st_d = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: st_d = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR:  st_d = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: st_d = tms ? TAP_UPD_DR : TAP_PAU_DR;
      TAP_PAU_DR: st_d = tms ? TAP_EX2_DR : TAP_PAU_DR;
      TAP_EX2_DR: st_d = tms ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: st_d = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: st_d = tms ? TAP_RESET  : TAP_CAP_IR;
      TAP_CAP_IR: st_d = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR:  st_d = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: st_d = tms ? TAP_UPD_IR : TAP_PAU_IR;
      TAP_PAU_IR: st_d = tms ? TAP_EX2_IR : TAP_PAU_IR;
      TAP_EX2_IR: st_d = tms ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: st_d = tms ? TAP_SEL_DR : TAP_IDLE;
      default:    st_d = TAP_RESET;
    endcase
  end

  // reset is carried into the link domain by two flops
  always_ff @(posedge tck) begin
    tck_rst_q <= {tck_rst_q[0], rst_b};
  end

  always_ff @(posedge tck) begin
    if (!tck_ok) begin
      st_q <= TAP_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  wire logic tap_rst = (st_q == TAP_RESET);
  wire logic cap_ir  = (st_q == TAP_CAP_IR);
  wire logic sh_ir   = (st_q == TAP_SH_IR);
  wire logic upd_ir  = (st_q == TAP_UPD_IR);
  wire logic cap_dr  = (st_q == TAP_CAP_DR);
  wire logic sh_dr   = (st_q == TAP_SH_DR);
  wire logic upd_dr  = (st_q == TAP_UPD_DR);

  // ==========================================================
  // instruction decode; unknown codes, boundary-scan ones too, bypass
  wire logic ir_en    = (ir_q == IR_ENABLE);
  wire logic ir_erase = (ir_q == IR_ERASE);
  wire logic ir_prog  = (ir_q == IR_PROGRAM) || ir_erase;
  wire logic ir_short = ir_en || (ir_q == IR_STATUS);
  wire logic req_pend = req_tgl_q ^ back_s2_q.ack_t;

  wire logic do_enable  = upd_dr && ir_en;
  wire logic do_disable = upd_ir && (ir_sr_q == IR_DISABLE);
  wire logic do_clear   = upd_ir && (ir_sr_q == IR_CLEAR) && chan_en_q;
  // a request made while the last one is unanswered is dropped
  wire logic do_req     = upd_dr && ir_prog && chan_en_q && !req_pend;

  wire logic [IR_W-1:0] ir_sr_d =
    cap_ir ? IR_CAPTURE :
    sh_ir  ? {tdi, ir_sr_q[IR_W-1:1]} : ir_sr_q;
  wire logic [LOAD_W-1:0] dr_d =
    (sh_dr && ir_prog) ? {tdi, dr_q[LOAD_W-1:1]} : dr_q;
  wire logic [OPT_W-1:0] sdr_d =
    (cap_dr && ir_short) ? (ir_en ? opt_q
                                  : {back_s2_q.busy, back_s2_q.err}) :
    (sh_dr && ir_short)  ? {tdi, sdr_q[OPT_W-1]} : sdr_q;
  wire logic byp_d = cap_dr ? 1'b0 : (sh_dr ? tdi : byp_q);
  wire logic tdo_bit =
    sh_ir    ? ir_sr_q[0] :
    ir_prog  ? dr_q[0]    :
    ir_short ? sdr_q[0]   : byp_q;

  // ==========================================================
  // shift and hold registers
  always_ff @(posedge tck) begin
    if (!tck_ok || tap_rst) begin
      ir_sr_q <= IR_BYPASS;
      ir_q    <= IR_BYPASS;
    end else begin
      ir_sr_q <= ir_sr_d;
      ir_q    <= upd_ir ? ir_sr_q : ir_q;
    end
  end

  always_ff @(posedge tck) begin
    if (!tck_ok) begin
      dr_q  <= '0;
      sdr_q <= '0;
      byp_q <= 1'b0;
    end else begin
      dr_q  <= dr_d;
      sdr_q <= sdr_d;
      byp_q <= byp_d;
    end
  end

  // enable options only ever come from the enable command
  always_ff @(posedge tck) begin
    if (!tck_ok || do_disable) begin
      chan_en_q <= 1'b0;
      opt_q     <= '0;
    end else if (do_enable) begin
      chan_en_q <= 1'b1;
      opt_q     <= sdr_q;
    end
  end

  // events leave the link domain as toggles
  always_ff @(posedge tck) begin
    if (!tck_ok) begin
      req_tgl_q  <= 1'b0;
      dis_tgl_q  <= 1'b0;
      clr_tgl_q  <= 1'b0;
      req_hold_q <= '0;
    end else begin
      req_tgl_q  <= req_tgl_q ^ do_req;
      dis_tgl_q  <= dis_tgl_q ^ do_disable;
      clr_tgl_q  <= clr_tgl_q ^ do_clear;
      req_hold_q <= do_req ? {ir_erase, dr_q} : req_hold_q;
    end
  end

  back_s back_w;
  always_ff @(posedge tck) begin
    if (!tck_ok) begin
      back_s1_q <= '0;
      back_s2_q <= '0;
    end else begin
      back_s1_q <= back_w;
      back_s2_q <= back_s1_q;
    end
  end

  // tdo changes on the falling edge; released outside shift states
  always_ff @(negedge tck) begin
    if (!tck_ok) begin
      tdo_pin <= PIN_OFF;
    end else begin
      tdo_pin.out  <= tdo_bit;
      tdo_pin.oe_b <= !(chan_en_q && (sh_ir || sh_dr));
    end
  end

  // ==========================================================
  // system domain
  fwd_s fwd_s1_q;
  fwd_s fwd_s2_q;
  fwd_s fwd_s3_q;
  logic ack_tgl_q;
  logic busy_q;
  logic err_q;
  logic dis_seen_q;

  wire fwd_s fwd_w = '{chip_rst_b: chip_rst_b, chan: chan_en_q,
                       ext: opt_q[OPT_EXT], od: opt_q[OPT_OD],
                       req_t: req_tgl_q, dis_t: dis_tgl_q,
                       clr_t: clr_tgl_q};
  assign back_w = '{ack_t: ack_tgl_q, busy: busy_q, err: err_q};

  wire logic req_ev   = fwd_s2_q.req_t ^ fwd_s3_q.req_t;
  wire logic dis_ev   = fwd_s2_q.dis_t ^ fwd_s3_q.dis_t;
  wire logic clr_ev   = fwd_s2_q.clr_t ^ fwd_s3_q.clr_t;
  wire logic rst_fall = fwd_s3_q.chip_rst_b && !fwd_s2_q.chip_rst_b;
  wire logic ext_on   = fwd_s2_q.chan && fwd_s2_q.ext;
  wire logic od_on    = fwd_s2_q.od;

  // a new failure wins over a clear in the same cycle
  wire logic err_clr = clr_ev || (rst_fall && dis_seen_q);
  wire logic err_d   = flash_err || (err_q && !err_clr);
  wire logic dis_seen_d = dis_ev || (dis_seen_q && !rst_fall);

  // open drain pulls low and floats high; push-pull drives both
  function automatic pin_drv_s pin_drive(input logic val,
                                         input logic od);
    pin_drive = od ? pin_drv_s'{out: 1'b0, oe_b: val}
                   : pin_drv_s'{out: val, oe_b: 1'b0};
  endfunction : pin_drive

  wire pin_drv_s stat_w = ext_on ? pin_drive(!flash_busy, od_on)
                                 : port_stat_drv;
  wire pin_drv_s err_w  = ext_on ? pin_drive(!err_q, od_on)
                                 : port_err_drv;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      fwd_s1_q <= FWD_RST;
      fwd_s2_q <= FWD_RST;
      fwd_s3_q <= FWD_RST;
    end else if (clk_en) begin
      fwd_s1_q <= fwd_w;
      fwd_s2_q <= fwd_s1_q;
      fwd_s3_q <= fwd_s2_q;
    end
  end

  // payload is stable: the link side waits for the ack toggle
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ack_tgl_q       <= 1'b0;
      flash_req       <= '0;
      flash_req_valid <= 1'b0;
    end else if (clk_en) begin
      ack_tgl_q       <= ack_tgl_q ^ req_ev;
      flash_req       <= req_ev ? req_hold_q : flash_req;
      flash_req_valid <= req_ev;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      busy_q     <= 1'b0;
      err_q      <= 1'b0;
      dis_seen_q <= 1'b0;
    end else if (clk_en) begin
      busy_q     <= flash_busy;
      err_q      <= err_d;
      dis_seen_q <= dis_seen_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      prog_status_out <= PIN_OFF;
      prog_error_flag <= PIN_OFF;
    end else if (clk_en) begin
      prog_status_out <= stat_w;
      prog_error_flag <= err_w;
    end
  end

  // ==========================================================
  // checks
  err_set_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && flash_err |=> err_q)
    else $error("error flag not set by a failed operation");

  err_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $fell(err_q) |-> $past(clr_ev || (rst_fall && dis_seen_q)))
    else $error("error flag left without clear or reset");

  err_pin_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && ext_on && !od_on && err_q
    |=> !prog_error_flag.out && !prog_error_flag.oe_b)
    else $error("error pin not driven low");

  stat_busy_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    clk_en && ext_on && flash_busy |=> !prog_status_out.out)
    else $error("status pin high while busy");

  stat_ready_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    clk_en && ext_on && !od_on && !flash_busy
    |=> prog_status_out.out && !prog_status_out.oe_b)
    else $error("status pin not high in read mode");

  od_drive_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && ext_on && od_on
    |=> !prog_status_out.out && !prog_error_flag.out)
    else $error("open drain pin drove high");

  pin_pass_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && !ext_on |=> prog_status_out == $past(port_stat_drv)
                          && prog_error_flag == $past(port_err_drv))
    else $error("shared pins not under port control");

  req_xfer_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && req_ev |=> flash_req_valid && flash_req == $past(req_hold_q))
    else $error("flash request lost or corrupted");

  tdo_off_a: assert property (@(posedge tck) disable iff (!tck_ok)
    !chan_en_q |-> tdo_pin.oe_b)
    else $error("tdo driven before enable");

  ext_only_a: assert property (@(posedge tck) disable iff (!tck_ok)
    $rose(opt_q[OPT_EXT]) |-> $past(upd_dr && ir_en))
    else $error("extension enabled by another command");

  tap_reset_a: assert property (@(posedge tck) disable iff (!tck_ok)
    tms [*5] |=> st_q == TAP_RESET)
    else $error("tap not reset by five tms highs");

endmodule : jtag_isp_config_port

// ===== rtl/jtag_isc_pkg.sv
// package: constants, tap states and carriers of the jtag config port
package jtag_isc_pkg;

  // ==========================================================
  // instruction register
  localparam int         IR_W       = 8;
  localparam logic [7:0] IR_CAPTURE = 8'h01;
  localparam logic [7:0] IR_BYPASS  = 8'hFF;
  localparam logic [7:0] IR_ENABLE  = 8'h0C;
  localparam logic [7:0] IR_DISABLE = 8'h0F;
  localparam logic [7:0] IR_CLEAR   = 8'h16;
  localparam logic [7:0] IR_PROGRAM = 8'h11;
  localparam logic [7:0] IR_ERASE   = 8'h12;
  localparam logic [7:0] IR_STATUS  = 8'h13;

  // ==========================================================
  // data register layouts
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int TGT_W  = 2;
  localparam int LOAD_W = TGT_W + ADDR_W + DATA_W;
  localparam int OPT_W  = 2;
  localparam int OPT_EXT = 0;
  localparam int OPT_OD  = 1;

  // programming targets
  localparam logic [1:0] TGT_MAIN = 2'h0;
  localparam logic [1:0] TGT_SEC  = 2'h1;
  localparam logic [1:0] TGT_PLD  = 2'h2;
  localparam logic [1:0] TGT_CFG  = 2'h3;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic              erase;
    logic [TGT_W-1:0]  target;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } flash_req_s;

  typedef struct packed {
    logic out;
    logic oe_b;
  } pin_drv_s;

  localparam pin_drv_s PIN_OFF = '{out: 1'b1, oe_b: 1'b1};

  // tck domain to sys_clk domain
  typedef struct packed {
    logic chip_rst_b;
    logic chan;
    logic ext;
    logic od;
    logic req_t;
    logic dis_t;
    logic clr_t;
  } fwd_s;

  localparam fwd_s FWD_RST = '{chip_rst_b: 1'b1, default: 1'b0};

  // sys_clk domain to tck domain
  typedef struct packed {
    logic ack_t;
    logic busy;
    logic err;
  } back_s;

  // ==========================================================
  // tap controller states
  typedef enum logic [15:0] {
    TAP_RESET  = 16'h0001,
    TAP_IDLE   = 16'h0002,
    TAP_SEL_DR = 16'h0004,
    TAP_CAP_DR = 16'h0008,
    TAP_SH_DR  = 16'h0010,
    TAP_EX1_DR = 16'h0020,
    TAP_PAU_DR = 16'h0040,
    TAP_EX2_DR = 16'h0080,
    TAP_UPD_DR = 16'h0100,
    TAP_SEL_IR = 16'h0200,
    TAP_CAP_IR = 16'h0400,
    TAP_SH_IR  = 16'h0800,
    TAP_EX1_IR = 16'h1000,
    TAP_PAU_IR = 16'h2000,
    TAP_EX2_IR = 16'h4000,
    TAP_UPD_IR = 16'h8000
  } tap_state_e;

endpackage : jtag_isc_pkg

// ===== tb/jtag_ctrl_model.sv
// partner model: external jtag programming controller on the test pins
`timescale 1ns/1ps
module jtag_ctrl_model
  import jtag_isc_pkg::*;
(
  // test-access pins
  output logic          tck,
  output logic          tms,
  output logic          tdi,
  input  wire pin_drv_s tdo_pin
);
  // ==========================================================
  // tck cycles, 12 ns; tck stands low between frames
  logic quiet;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    quiet = 1'b1;
  end

  // tms and tdi move only while tck is low
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #6;
    // a released tdo reads as the inverse of tdo_pin.out, which keeps following tdo_bit
    o = tdo_pin.oe_b ? !tdo_pin.out : tdo_pin.out;
    if (tdo_pin.oe_b !== 1'b1) quiet = 1'b0;
    tck = 1'b1;
    #6;
    tck = 1'b0;
  endtask : step

  task automatic seq(input logic [7:0] m, input int n);
    logic o;
    for (int i = 0; i < n; i++) step(m[i], 1'b0, o);
  endtask : seq

  // idle -> shift, n bits lsb first, update -> idle
  task automatic shift(input logic ir, input logic [31:0] v, input int n,
                       output logic [31:0] cap);
    logic o;
    cap = '0;
    quiet = 1'b1;
    if (ir) seq(8'h03, 4);
    else seq(8'h01, 3);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, v[i], o);
      cap[i] = o;
    end
    seq(8'h01, 2);
  endtask : shift
endmodule : jtag_ctrl_model

// ===== tb/jtag_isp_config_port_test.sv
// self-checking bench for the jtag configuration port
`timescale 1ns/1ps
module jtag_isp_config_port_test import jtag_isc_pkg::*;;
  // ==========================================================
  // pin values {out, oe_b}
  localparam pin_drv_s PORT = 2'h1;
  localparam pin_drv_s PP_HI = 2'h2;
  localparam pin_drv_s PP_LO = 2'h0;
  localparam pin_drv_s OD_HI = 2'h1;

  logic       sys_clk    = 1'b0;
  logic       rst_b      = 1'b0;
  logic       clk_en     = 1'b1;
  logic       chip_rst_b = 1'b0;  // low except while chip_pulse raises it
  logic       flash_busy = 1'b0;
  logic       flash_err  = 1'b0;
  logic       tck;
  logic       tms;
  logic       tdi;
  pin_drv_s   tdo_pin;
  pin_drv_s   prog_status_out;
  pin_drv_s   prog_error_flag;
  flash_req_s flash_req;
  flash_req_s got_req;
  logic       flash_req_valid;
  int         n_req      = 0;
  int         n_mismatch = 0;
  int         num_checks = 0;

  always #4 sys_clk = ~sys_clk;

  jtag_ctrl_model ctrl (.tck(tck), .tms(tms), .tdi(tdi), .tdo_pin(tdo_pin));

  jtag_isp_config_port dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en), .tck(tck),
    .tms(tms), .tdi(tdi), .tdo_pin(tdo_pin), .chip_rst_b(chip_rst_b),
    .flash_busy(flash_busy), .flash_err(flash_err), .flash_req(flash_req),
    .flash_req_valid(flash_req_valid), .port_stat_drv(PORT),
    .port_err_drv(PORT), .prog_status_out(prog_status_out),
    .prog_error_flag(prog_error_flag));

  always @(posedge sys_clk) begin
    if (flash_req_valid === 1'b1) begin
      got_req <= flash_req;
      n_req   <= n_req + 1;
    end
  end

  // ==========================================================
  // helpers
  task automatic chk_pin(input string nm, input pin_drv_s e,
                         input pin_drv_s g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_pin

  task automatic chk_vec(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_vec

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc

  task automatic ir(input logic [7:0] code);
    logic [31:0] c;
    ctrl.shift(1'b1, 32'(code), 8, c);
    cyc(6);
  endtask : ir

  task automatic enable(input logic [1:0] opt);
    logic [31:0] c;
    ir(IR_ENABLE);
    ctrl.shift(1'b0, 32'(opt), 2, c);
    cyc(6);  // extension pins switch over a few cycles later
  endtask : enable

  task automatic busy(input logic b);
    @(negedge sys_clk);
    flash_busy = b;
    cyc(3);
  endtask : busy

  task automatic err_pulse;
    @(negedge sys_clk);
    flash_err = 1'b1;
    cyc(1);
    flash_err = 1'b0;
    cyc(4);
  endtask : err_pulse

  // chip reset asserts again at the end of the pulse
  task automatic chip_pulse;
    @(negedge sys_clk);
    chip_rst_b = 1'b1;
    cyc(4);
    chip_rst_b = 1'b0;
    cyc(6);
  endtask : chip_pulse

  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  // ==========================================================
  // scenarios
  task automatic t_closed;
    logic [31:0] c;
    chk_pin("status at reset", PORT, prog_status_out);
    chk_pin("error at reset", PORT, prog_error_flag);
    ctrl.shift(1'b1, 32'(IR_PROGRAM), 8, c);
    chk_vec("tdo released", 1, ctrl.quiet);
    ctrl.shift(1'b0, 32'h0155AA, 26, c);
    cyc(10);
    chk_vec("request while closed", 0, n_req);
    chk_pin("status closed", PORT, prog_status_out);
  endtask : t_closed

  task automatic t_push_pull;
    logic [31:0] c;
    enable(2'h1);
    chk_pin("status ready", PP_HI, prog_status_out);
    chk_pin("error idle", PP_HI, prog_error_flag);
    busy(1'b1);
    chk_pin("status busy", PP_LO, prog_status_out);
    busy(1'b0);
    chk_pin("status back", PP_HI, prog_status_out);
    clk_en = 1'b0;  // frozen: the pin must not follow busy
    busy(1'b1);
    chk_pin("status frozen", PP_HI, prog_status_out);
    clk_en = 1'b1;
    busy(1'b1);
    chk_pin("status thawed", PP_LO, prog_status_out);
    busy(1'b0);
    ctrl.shift(1'b1, 32'(IR_BYPASS), 8, c);
    chk_vec("ir capture", 32'(IR_CAPTURE), c);
    chk_vec("tdo driven", 0, ctrl.quiet);
  endtask : t_push_pull

  task automatic t_error;
    logic [31:0] c;
    err_pulse();
    chk_pin("error set", PP_LO, prog_error_flag);
    busy(1'b1);
    ir(IR_STATUS);
    ctrl.shift(1'b0, 32'h0, 2, c);
    chk_vec("status scan", 32'h3, c);
    busy(1'b0);
    chip_pulse();
    chk_pin("error kept", PP_LO, prog_error_flag);
    ir(IR_CLEAR);
    chk_pin("error cleared", PP_HI, prog_error_flag);
  endtask : t_error

  task automatic t_program;
    flash_req_s  e;
    logic [31:0] c;
    int          base;
    for (int i = 0; i < 5; i++) begin
      e.erase  = (i == 4);
      e.target = i[1:0];
      e.addr   = 16'hA5C0 + 16'(i);
      e.data   = 8'h3C ^ 8'(i);
      base     = n_req;
      ir(e.erase ? IR_ERASE : IR_PROGRAM);
      ctrl.shift(1'b0, 32'({e.target, e.addr, e.data}), 26, c);
      for (int k = 0; k < 40 && n_req == base; k++) cyc(1);
      if (n_req == base) begin
        n_mismatch++;
        $display("mismatch flash request expected valid seen none");
        stop_test();
      end
      chk_vec("flash request", 32'(e), 32'(got_req));
      ctrl.seq(8'h00, 4);  // leave time for the acknowledge
    end
  endtask : t_program

  task automatic t_open_drain;
    enable(2'h3);
    chk_pin("od ready", OD_HI, prog_status_out);
    busy(1'b1);
    chk_pin("od busy", PP_LO, prog_status_out);
    busy(1'b0);
    chk_pin("od error idle", OD_HI, prog_error_flag);
    err_pulse();
    chk_pin("od error set", PP_LO, prog_error_flag);
  endtask : t_open_drain

  // busy held so that an open-drain status cannot pass for the port
  task automatic t_disable;
    logic [31:0] c;
    busy(1'b1);
    ir(IR_DISABLE);
    chk_pin("status off", PORT, prog_status_out);
    chk_pin("error off", PORT, prog_error_flag);
    ctrl.shift(1'b1, 32'(IR_BYPASS), 8, c);
    chk_vec("tdo off again", 1, ctrl.quiet);
    chip_pulse();
    busy(1'b0);
    enable(2'h1);
    chk_pin("error reset", PP_HI, prog_error_flag);
  endtask : t_disable

  // ==========================================================
  // main sequence; tck runs while reset is held
  initial begin
    ctrl.seq(8'hFF, 8);
    @(negedge sys_clk);
    rst_b = 1'b1;
    ctrl.seq(8'h1F, 5);
    ctrl.seq(8'h00, 1);
    cyc(2);
    t_closed();
    t_push_pull();
    t_error();
    t_program();
    t_open_drain();
    t_disable();
    stop_test();
  end

  initial begin
    #200000;
    n_mismatch++;
    $display("mismatch run time expected end seen timeout");
    stop_test();
  end
endmodule : jtag_isp_config_port_test
